// [design/path_mgr_params.svh]
// offsets, fields, reset values and timing for the serial console path manager
`ifndef PATH_MGR_PARAMS_SVH
`define PATH_MGR_PARAMS_SVH
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_LOGOUT      8'h08
`define REG_BAUD        8'h0c
`define REG_STR_SEL     8'h10
`define REG_STR_DATA    8'h14
`define REG_STR_INDEX   8'h18
`define CTRL_END_BIT    8
`define CTRL_INIT_BIT   9
`define CTRL_COMMIT_BIT 10
`define MODE_RST        2'h0
`define LOGOUT_RST      4'h2
`define LOGOUT_MAX      4'h9
`define BAUD_RST        18'h02580
`define ESC_MAX_LEN     14
`define INIT_MAX_LEN    31
`define DIAL_MAX_LEN    31
`define PASS_MAX_LEN    14
`define USER_MAX_LEN    63
`define BASE_ESC        8'h00
`define BASE_INIT       8'h10
`define BASE_DIAL       8'h30
`define BASE_PASS0      8'h60
`define BASE_PASS1      8'h70
`define BASE_USER       8'h80
`define MINUTE_NS       64'd60000000000
`define CLK_PERIOD_NS   64'd10
`endif

// [design/path_mgr_pkg.sv]
// types of the serial console path manager
package path_mgr_pkg;
	typedef enum logic [1:0] {
		PATH_THROUGH,
		PATH_LISTEN,
		PATH_SOFT_SKIP,
		PATH_HARD_SKIP
	} path_mode_t;
	typedef enum logic [2:0] {
		SEL_ESC,
		SEL_INIT,
		SEL_DIAL,
		SEL_USER,
		SEL_PASS,
		SEL_VERIFY
	} str_sel_t;
endpackage

// [design/serial_console_path_manager.sv]
// serial console path manager: path modes, escape scan, session and settings store
`include "path_mgr_params.svh"
module serial_console_path_manager #(
	parameter int                  ESC_MAX        = `ESC_MAX_LEN,
	parameter int                  INIT_MAX       = `INIT_MAX_LEN,
	parameter int                  DIAL_MAX       = `DIAL_MAX_LEN,
	parameter int                  PASS_MAX       = `PASS_MAX_LEN,
	parameter int                  USER_MAX       = `USER_MAX_LEN,
	parameter logic [35:0]         CYCLES_PER_MIN = 36'(`MINUTE_NS / `CLK_PERIOD_NS)
) (
	input  wire logic              sys_clk_i,
	input  wire logic              resetn_i,
	input  wire logic [7:0]        avs_address_i,
	input  wire logic              avs_read_i,
	input  wire logic              avs_write_i,
	input  wire logic [31:0]       avs_writedata_i,
	output logic      [31:0]       avs_readdata_o,
	output logic                   avs_waitrequest_o,
	input  wire logic [7:0]        host_byte_i,
	input  wire logic              host_valid_i,
	input  wire logic [7:0]        modem_byte_i,
	input  wire logic              modem_valid_i,
	input  wire logic              local_enter_i,
	input  wire logic              system_power_on_i,
	input  wire logic              alert_i,
	input  wire logic              carrier_detect_i,
	input  wire logic              serial_flow_setting_i,
	output logic      [7:0]        modem_byte_o,
	output logic                   modem_valid_o,
	output logic      [7:0]        host_byte_o,
	output logic                   host_valid_o,
	output logic                   path_bypass_o,
	output logic                   remote_enable_o,
	output logic                   session_active_o,
	output logic                   session_modem_o,
	output logic                   hangup_o,
	output logic                   modem_init_o,
	output logic                   modem_flow_o,
	output logic                   modem_cd_enable_o,
	output logic      [17:0]       baud_rate_o
);
	logic [7:0] mem [0:255];
	path_mgr_pkg::path_mode_t mode_reg, mode_next;
	path_mgr_pkg::str_sel_t   sel_reg, sel_next;
	logic [7:0]  len_reg [0:5];
	logic [7:0]  len_next [0:5];
	logic        wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [3:0]  logout_reg, logout_next;
	logic [17:0] baud_reg, baud_next;
	logic [7:0]  rd_idx_reg, rd_idx_next;
	logic [7:0]  esc_idx_reg, esc_idx_next;
	logic        sess_reg, sess_next;
	logic        smodem_reg, smodem_next;
	logic        slot_reg, slot_next;
	logic        pass_set_reg, pass_set_next;
	logic        pass_err_reg, pass_err_next;
	logic [7:0]  vcnt_reg, vcnt_next;
	logic        vok_reg, vok_next;
	logic        cd_prev_reg, cd_prev_next;
	logic [35:0] cyc_reg, cyc_next;
	logic [6:0]  idle_min_reg, idle_min_next;
	logic [7:0]  mbyte_reg, mbyte_next;
	logic        mvalid_reg, mvalid_next;
	logic [7:0]  hbyte_reg, hbyte_next;
	logic        hvalid_reg, hvalid_next;
	logic        hang_reg, hang_next;
	logic        init_reg, init_next;
	logic        flow_reg, flow_next;
	logic        cden_reg, cden_next;
	logic        bypass_reg, bypass_next;
	logic        remen_reg, remen_next;
	logic        mem_we;
	logic [7:0]  mem_waddr;
	logic [7:0]  mem_wdata;
	logic        wr_acc;
	logic        rd_acc;
	logic        carrier_lost;
	logic        idle_timeout;
	logic        scan_valid;
	logic [7:0]  scan_byte;
	logic        esc_hit;
	logic [2:0]  wr_region;
	logic [7:0]  pass_base;
	logic [7:0]  pass_len;

	function automatic logic [7:0] region_base(input logic [2:0] r);
		case (r)
			3'h0:    region_base = `BASE_ESC;
			3'h1:    region_base = `BASE_INIT;
			3'h2:    region_base = `BASE_DIAL;
			3'h3:    region_base = `BASE_USER;
			3'h4:    region_base = `BASE_PASS0;
			default: region_base = `BASE_PASS1;
		endcase
	endfunction

	function automatic logic [7:0] region_max(input logic [2:0] r);
		case (r)
			3'h0:    region_max = 8'(ESC_MAX);
			3'h1:    region_max = 8'(INIT_MAX);
			3'h2:    region_max = 8'(DIAL_MAX);
			3'h3:    region_max = 8'(USER_MAX);
			default: region_max = 8'(PASS_MAX);
		endcase
	endfunction

	function automatic logic [7:0] to_upper(input logic [7:0] c);
		to_upper = (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
	endfunction

	// new password entry always lands in the idle slot, so a failed verify leaves the live one
	assign pass_base = region_base({2'h2, ~slot_reg});
	assign pass_len  = len_reg[{2'h2, ~slot_reg}];
	assign wr_region = (sel_reg == path_mgr_pkg::SEL_PASS || sel_reg == path_mgr_pkg::SEL_VERIFY) ?
		{2'h2, ~slot_reg} : sel_reg;
	assign wr_acc = avs_write_i && !wait_reg;
	assign rd_acc = avs_read_i && !wait_reg;
	assign carrier_lost = cd_prev_reg && !carrier_detect_i;
	assign idle_timeout = (logout_reg != 4'h0) && (idle_min_reg >= 7'(logout_reg) * 7'h0a);

	// through scans the host stream, listen taps the modem stream; skip modes scan nothing
	always_comb begin
		scan_valid = 1'b0;
		scan_byte  = host_byte_i;
		if (!sess_reg && mode_reg == path_mgr_pkg::PATH_THROUGH) begin
			scan_valid = host_valid_i;
		end else if (!sess_reg && mode_reg == path_mgr_pkg::PATH_LISTEN) begin
			scan_valid = modem_valid_i;
			scan_byte  = modem_byte_i;
		end
	end

	// a mismatch restarts at the first character without rechecking it against the sequence
	assign esc_hit = scan_valid && len_reg[0] != 8'h00 && scan_byte == mem[esc_idx_reg] &&
		esc_idx_reg + 8'h01 == len_reg[0];

	always_comb begin
		wait_next     = !((avs_read_i || avs_write_i) && wait_reg);
		rdata_next    = rdata_reg;
		mode_next     = mode_reg;
		sel_next      = sel_reg;
		len_next      = len_reg;
		logout_next   = logout_reg;
		baud_next     = baud_reg;
		rd_idx_next   = rd_idx_reg;
		esc_idx_next  = esc_idx_reg;
		sess_next     = sess_reg;
		smodem_next   = smodem_reg;
		slot_next     = slot_reg;
		pass_set_next = pass_set_reg;
		pass_err_next = pass_err_reg;
		vcnt_next     = vcnt_reg;
		vok_next      = vok_reg;
		cd_prev_next  = carrier_detect_i;
		cyc_next      = cyc_reg;
		idle_min_next = idle_min_reg;
		mbyte_next    = mbyte_reg;
		mvalid_next   = 1'b0;
		hbyte_next    = hbyte_reg;
		hvalid_next   = 1'b0;
		hang_next     = 1'b0;
		init_next     = 1'b0;
		flow_next     = flow_reg;
		cden_next     = cden_reg;
		mem_we        = 1'b0;
		mem_waddr     = 8'h00;
		mem_wdata     = 8'h00;

		// forwarding in through mode: host bytes while no session is open, modem bytes while no modem session is open
		if (mode_reg == path_mgr_pkg::PATH_THROUGH && !sess_reg && host_valid_i) begin
			mvalid_next = 1'b1;
			mbyte_next  = host_byte_i;
		end
		if (mode_reg == path_mgr_pkg::PATH_THROUGH && !smodem_reg && modem_valid_i) begin
			hvalid_next = 1'b1;
			hbyte_next  = modem_byte_i;
		end

		if (scan_valid && len_reg[0] != 8'h00) begin
			if (esc_hit || scan_byte != mem[esc_idx_reg]) begin
				esc_idx_next = 8'h00;
			end else begin
				esc_idx_next = esc_idx_reg + 8'h01;
			end
		end

		// soft skip falls back to listen when the host is off, on alert or carrier loss
		if (mode_reg == path_mgr_pkg::PATH_SOFT_SKIP &&
			(!system_power_on_i || alert_i || carrier_lost)) begin
			mode_next = path_mgr_pkg::PATH_LISTEN;
		end

		// idle minutes count only in a modem session with no modem traffic
		if (!smodem_reg || modem_valid_i) begin
			cyc_next      = 36'h0;
			idle_min_next = 7'h00;
		end else if (cyc_reg == CYCLES_PER_MIN - 36'h1) begin
			cyc_next      = 36'h0;
			idle_min_next = (idle_min_reg == 7'h7f) ? idle_min_reg : idle_min_reg + 7'h01;
		end else begin
			cyc_next = cyc_reg + 36'h1;
		end

		if (sess_reg) begin
			if ((wr_acc && avs_address_i == `REG_CTRL && avs_writedata_i[`CTRL_END_BIT]) ||
				(smodem_reg && (idle_timeout || carrier_lost))) begin
				sess_next   = 1'b0;
				smodem_next = 1'b0;
				hang_next   = smodem_reg;
			end
		end else if (local_enter_i) begin
			sess_next = 1'b1;
		end else if (esc_hit && pass_set_reg) begin
			sess_next   = 1'b1;
			smodem_next = 1'b1;
		end

		if (avs_read_i && wait_reg) begin
			unique case (avs_address_i)
				`REG_CTRL:   rdata_next = {30'h0, mode_reg};
				`REG_STATUS: rdata_next = {23'h0, mode_reg != path_mgr_pkg::PATH_THROUGH,
					modem_flow_o, cden_reg, pass_err_reg, pass_set_reg, smodem_reg,
					sess_reg, mode_reg};
				`REG_LOGOUT: rdata_next = {28'h0, logout_reg};
				`REG_BAUD:   rdata_next = {14'h0, baud_reg};
				`REG_STR_SEL: rdata_next = {29'h0, sel_reg};
				`REG_STR_DATA: begin
					rdata_next = {16'h0, len_reg[wr_region], 8'h00};
					if (wr_region[2:1] != 2'h2 && rd_idx_reg < len_reg[wr_region]) begin
						rdata_next[7:0] = mem[region_base(wr_region) + rd_idx_reg];
					end
				end
				`REG_STR_INDEX: rdata_next = {24'h0, rd_idx_reg};
				default:     rdata_next = 32'h0;
			endcase
		end
		if (rd_acc && avs_address_i == `REG_STR_DATA) begin
			rd_idx_next = rd_idx_reg + 8'h01;
		end

		if (wr_acc) begin
			unique case (avs_address_i)
				`REG_CTRL: begin
					mode_next = path_mgr_pkg::path_mode_t'(avs_writedata_i[1:0]);
					if (avs_writedata_i[`CTRL_INIT_BIT] &&
						mode_reg != path_mgr_pkg::PATH_HARD_SKIP) begin
						init_next = 1'b1;
						flow_next = serial_flow_setting_i;
						cden_next = 1'b1;
					end
					if (avs_writedata_i[`CTRL_COMMIT_BIT]) begin
						if (vok_reg && vcnt_reg == pass_len && pass_len != 8'h00) begin
							slot_next     = ~slot_reg;
							pass_set_next = 1'b1;
							pass_err_next = 1'b0;
						end else begin
							pass_err_next = 1'b1;
						end
					end
				end
				`REG_LOGOUT: begin
					if (avs_writedata_i[3:0] <= `LOGOUT_MAX) begin
						logout_next = avs_writedata_i[3:0];
					end
				end
				`REG_BAUD: baud_next = avs_writedata_i[17:0];
				`REG_STR_SEL: begin
					sel_next    = path_mgr_pkg::str_sel_t'(avs_writedata_i[2:0]);
					rd_idx_next = 8'h00;
					vcnt_next   = 8'h00;
					vok_next    = 1'b1;
					if (avs_writedata_i[2:0] == 3'h0) begin
						esc_idx_next = 8'h00;
					end
					if (avs_writedata_i[2:0] < 3'h4) begin
						len_next[avs_writedata_i[2:0]] = 8'h00;
					end else if (avs_writedata_i[2:0] == 3'h4) begin
						len_next[{2'h2, ~slot_reg}] = 8'h00;
					end
				end
				`REG_STR_DATA: begin
					if (sel_reg == path_mgr_pkg::SEL_VERIFY) begin
						if (vcnt_reg >= pass_len ||
							mem[pass_base + vcnt_reg] != avs_writedata_i[7:0]) begin
							vok_next = 1'b0;
						end
						vcnt_next = (vcnt_reg == 8'hff) ? vcnt_reg : vcnt_reg + 8'h01;
					end else if (len_reg[wr_region] < region_max(wr_region)) begin
						mem_we    = 1'b1;
						mem_waddr = region_base(wr_region) + len_reg[wr_region];
						mem_wdata = avs_writedata_i[7:0];
						if (sel_reg == path_mgr_pkg::SEL_INIT ||
							sel_reg == path_mgr_pkg::SEL_DIAL) begin
							mem_wdata = to_upper(avs_writedata_i[7:0]);
						end
						len_next[wr_region] = len_reg[wr_region] + 8'h01;
					end
				end
				`REG_STR_INDEX: rd_idx_next = avs_writedata_i[7:0];
				default: begin
				end
			endcase
		end

		// decoded from the next mode so the registered outputs track the mode with no lag
		bypass_next = mode_next != path_mgr_pkg::PATH_THROUGH;
		remen_next  = mode_next != path_mgr_pkg::PATH_HARD_SKIP;
	end

	// string store carries no reset; lengths gate every read of it
	always_ff @(posedge sys_clk_i) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wait_reg     <= 1'b1;
			rdata_reg    <= 32'h0;
			mode_reg     <= path_mgr_pkg::path_mode_t'(`MODE_RST);
			sel_reg      <= path_mgr_pkg::SEL_ESC;
			for (int i = 0; i < 6; i++) begin
				len_reg[i] <= 8'h00;
			end
			logout_reg   <= `LOGOUT_RST;
			baud_reg     <= `BAUD_RST;
			rd_idx_reg   <= 8'h00;
			esc_idx_reg  <= 8'h00;
			sess_reg     <= 1'b0;
			smodem_reg   <= 1'b0;
			slot_reg     <= 1'b0;
			pass_set_reg <= 1'b0;
			pass_err_reg <= 1'b0;
			vcnt_reg     <= 8'h00;
			vok_reg      <= 1'b1;
			cd_prev_reg  <= 1'b0;
			cyc_reg      <= 36'h0;
			idle_min_reg <= 7'h00;
			mbyte_reg    <= 8'h00;
			mvalid_reg   <= 1'b0;
			hbyte_reg    <= 8'h00;
			hvalid_reg   <= 1'b0;
			hang_reg     <= 1'b0;
			init_reg     <= 1'b0;
			flow_reg     <= 1'b0;
			cden_reg     <= 1'b0;
			bypass_reg   <= (`MODE_RST != 2'h0);
			remen_reg    <= (`MODE_RST != 2'h3);
		end else begin
			wait_reg     <= wait_next;
			rdata_reg    <= rdata_next;
			mode_reg     <= mode_next;
			sel_reg      <= sel_next;
			len_reg      <= len_next;
			logout_reg   <= logout_next;
			baud_reg     <= baud_next;
			rd_idx_reg   <= rd_idx_next;
			esc_idx_reg  <= esc_idx_next;
			sess_reg     <= sess_next;
			smodem_reg   <= smodem_next;
			slot_reg     <= slot_next;
			pass_set_reg <= pass_set_next;
			pass_err_reg <= pass_err_next;
			vcnt_reg     <= vcnt_next;
			vok_reg      <= vok_next;
			cd_prev_reg  <= cd_prev_next;
			cyc_reg      <= cyc_next;
			idle_min_reg <= idle_min_next;
			mbyte_reg    <= mbyte_next;
			mvalid_reg   <= mvalid_next;
			hbyte_reg    <= hbyte_next;
			hvalid_reg   <= hvalid_next;
			hang_reg     <= hang_next;
			init_reg     <= init_next;
			flow_reg     <= flow_next;
			cden_reg     <= cden_next;
			bypass_reg   <= bypass_next;
			remen_reg    <= remen_next;
		end
	end

	assign avs_waitrequest_o = wait_reg;
	assign avs_readdata_o    = rdata_reg;
	assign modem_byte_o      = mbyte_reg;
	assign modem_valid_o     = mvalid_reg;
	assign host_byte_o       = hbyte_reg;
	assign host_valid_o      = hvalid_reg;
	assign path_bypass_o     = bypass_reg;
	assign remote_enable_o   = remen_reg;
	assign session_active_o  = sess_reg;
	assign session_modem_o   = smodem_reg;
	assign hangup_o          = hang_reg;
	assign modem_init_o      = init_reg;
	assign modem_flow_o      = flow_reg;
	assign modem_cd_enable_o = cden_reg;
	assign baud_rate_o       = baud_reg;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_fwd;
		mode_reg == path_mgr_pkg::PATH_THROUGH && !sess_reg && host_valid_i
			|=> modem_valid_o && modem_byte_o == $past(host_byte_i);
	endproperty
	a_fwd: assert property (p_fwd) else $error("host byte not forwarded");
	property p_single;
		sess_reg && !smodem_reg && local_enter_i |=> !smodem_reg;
	endproperty
	a_single: assert property (p_single) else $error("second session opened");
	property p_soft_off;
		mode_reg == path_mgr_pkg::PATH_SOFT_SKIP && !system_power_on_i && !wr_acc
			|=> mode_reg == path_mgr_pkg::PATH_LISTEN;
	endproperty
	a_soft_off: assert property (p_soft_off) else $error("soft skip kept, host off");
	property p_skip_quiet;
		mode_reg != path_mgr_pkg::PATH_THROUGH |=> !modem_valid_o && !host_valid_o;
	endproperty
	a_skip_quiet: assert property (p_skip_quiet) else $error("data forwarded in bypass");
	property p_no_remote;
		(mode_reg == path_mgr_pkg::PATH_HARD_SKIP || mode_reg == path_mgr_pkg::PATH_SOFT_SKIP)
			&& !sess_reg |=> !smodem_reg;
	endproperty
	a_no_remote: assert property (p_no_remote) else $error("remote entry in skip");
	property p_local;
		!sess_reg && local_enter_i |=> sess_reg && !smodem_reg;
	endproperty
	a_local: assert property (p_local) else $error("local entry refused");
	property p_init;
		wr_acc && avs_address_i == `REG_CTRL && avs_writedata_i[`CTRL_INIT_BIT] &&
			mode_reg != path_mgr_pkg::PATH_HARD_SKIP
			|=> modem_init_o && modem_cd_enable_o && modem_flow_o == $past(serial_flow_setting_i);
	endproperty
	a_init: assert property (p_init) else $error("modem init wrong");
	property p_timeout;
		smodem_reg && idle_timeout |=> !sess_reg && hangup_o ##1 !hangup_o;
	endproperty
	a_timeout: assert property (p_timeout) else $error("idle session kept");
	property p_nopass;
		!pass_set_reg && !sess_reg |=> !smodem_reg;
	endproperty
	a_nopass: assert property (p_nopass) else $error("modem entry without password");
	property p_pass_err;
		wr_acc && avs_address_i == `REG_CTRL && avs_writedata_i[`CTRL_COMMIT_BIT] && !vok_reg
			|=> pass_err_reg && $stable(slot_reg);
	endproperty
	a_pass_err: assert property (p_pass_err) else $error("bad verify accepted");
	property p_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
	endproperty
	a_wait: assert property (p_wait) else $error("bus answer late");
endmodule

// [tb/far_side_model.sv]
// far side model: host serial port and external modem byte streams plus modem carrier
module far_side_model (
	input  wire logic       sys_clk_i,
	output logic      [7:0] host_byte_o,
	output logic            host_valid_o,
	output logic      [7:0] modem_byte_o,
	output logic            modem_valid_o,
	output logic            carrier_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		host_byte_o = 8'h5a;
		host_valid_o = 1'b0;
		modem_byte_o = 8'ha5;
		modem_valid_o = 1'b0;
		carrier_o = 1'b1;
	end
	// between bytes the lines show the inverse of the last byte, so a stale copy is never seen
	task automatic send_host(input logic [7:0] b);
		@(posedge sys_clk_i);
		host_byte_o <= b;
		host_valid_o <= 1'b1;
		@(posedge sys_clk_i);
		host_byte_o <= ~b;
		host_valid_o <= 1'b0;
	endtask
	task automatic send_modem(input logic [7:0] b);
		@(posedge sys_clk_i);
		modem_byte_o <= b;
		modem_valid_o <= 1'b1;
		@(posedge sys_clk_i);
		modem_byte_o <= ~b;
		modem_valid_o <= 1'b0;
	endtask
	task automatic set_carrier(input logic c);
		@(posedge sys_clk_i);
		carrier_o <= c;
	endtask
endmodule

// [tb/serial_console_path_manager_tb_top.sv]
// self-checking bench of the serial console path manager
`include "path_mgr_params.svh"
module serial_console_path_manager_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [7:0]  avs_address_i, host_byte_i, modem_byte_i, modem_byte_o, host_byte_o;
	logic [31:0] avs_writedata_i, avs_readdata_o, rdat;
	logic        host_valid_i, modem_valid_i, local_enter_i, system_power_on_i, alert_i;
	logic        carrier_detect_i, serial_flow_setting_i, modem_valid_o, host_valid_o;
	logic        path_bypass_o, remote_enable_o, session_active_o, session_modem_o;
	logic        hangup_o, modem_init_o, modem_flow_o, modem_cd_enable_o;
	logic [17:0] baud_rate_o;
	int          err_total, n_tests, hang_cnt, n;
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// ten cycles a minute keeps the idle timeout short
	serial_console_path_manager #(.CYCLES_PER_MIN(36'h00000000a)) i_dut (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.host_byte_i(host_byte_i), .host_valid_i(host_valid_i), .modem_byte_i(modem_byte_i),
		.modem_valid_i(modem_valid_i), .local_enter_i(local_enter_i),
		.system_power_on_i(system_power_on_i), .alert_i(alert_i),
		.carrier_detect_i(carrier_detect_i), .serial_flow_setting_i(serial_flow_setting_i),
		.modem_byte_o(modem_byte_o), .modem_valid_o(modem_valid_o), .host_byte_o(host_byte_o),
		.host_valid_o(host_valid_o), .path_bypass_o(path_bypass_o),
		.remote_enable_o(remote_enable_o), .session_active_o(session_active_o),
		.session_modem_o(session_modem_o), .hangup_o(hangup_o), .modem_init_o(modem_init_o),
		.modem_flow_o(modem_flow_o), .modem_cd_enable_o(modem_cd_enable_o),
		.baud_rate_o(baud_rate_o));
	far_side_model i_far (.sys_clk_i(sys_clk_i), .host_byte_o(host_byte_i),
		.host_valid_o(host_valid_i), .modem_byte_o(modem_byte_i),
		.modem_valid_o(modem_valid_i), .carrier_o(carrier_detect_i));
	always @(posedge sys_clk_i) begin
		if (hangup_o === 1'b1) hang_cnt++;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge sys_clk_i);
		#1;
	endtask
	// request held until waitrequest is sampled low; the watchdog ends a hang
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge sys_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= ~wr;
		do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
		rdat = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(rdat & m, e);
	endtask
	task automatic str_fill(input logic [2:0] s, input logic [7:0] b, input int k);
		bus(`REG_STR_SEL, 1'b1, {29'h0, s});
		repeat (k) bus(`REG_STR_DATA, 1'b1, {24'h0, b});
	endtask
	task automatic esc_seq(input logic modem);
		repeat (2) if (modem) i_far.send_modem(8'h1b); else i_far.send_host(8'h1b);
		tick(2);
	endtask
	task automatic local_pulse();
		@(posedge sys_clk_i);
		local_enter_i <= 1'b1;
		@(posedge sys_clk_i);
		local_enter_i <= 1'b0;
		tick(2);
	endtask
	task automatic close_out();
		if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		close_out();
	end
	initial begin
		{err_total, n_tests, hang_cnt} = '0;
		{resetn_i, avs_read_i, avs_write_i, local_enter_i, alert_i} = '0;
		{avs_address_i, avs_writedata_i, serial_flow_setting_i} = '0;
		system_power_on_i = 1'b1;
		repeat (20) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		rd_chk(`REG_STATUS, 32'hffffffff, 32'h0);
		rd_chk(`REG_LOGOUT, 32'hf, 32'h2);
		rd_chk(`REG_BAUD, 32'h3ffff, 32'h2580);
		rd_chk(8'hfc, 32'hffffffff, 32'h0);
		chk({remote_enable_o, path_bypass_o}, 2'b10);
		i_far.send_host(8'h41);
		#1 chk({modem_valid_o, modem_byte_o}, 9'h141);
		i_far.send_modem(8'h5a);
		#1 chk({host_valid_o, host_byte_o}, 9'h15a);
		str_fill(3'h0, 8'h1b, 15);
		rd_chk(`REG_STR_DATA, 32'hffff, 32'h0e1b);
		str_fill(3'h0, 8'h1b, 2);
		str_fill(3'h2, 8'h61, 1);
		rd_chk(`REG_STR_DATA, 32'hffff, 32'h0141);
		str_fill(3'h1, 8'h62, 32);
		rd_chk(`REG_STR_DATA, 32'hffff, 32'h1f42);
		str_fill(3'h3, 8'h75, 64);
		rd_chk(`REG_STR_DATA, 32'hffff, 32'h3f75);
		esc_seq(1'b0);
		chk(session_active_o, 1'b0);
		str_fill(3'h4, 8'h78, 1);
		str_fill(3'h5, 8'h79, 1);
		bus(`REG_CTRL, 1'b1, 32'h400);
		rd_chk(`REG_STATUS, 32'h30, 32'h20);
		str_fill(3'h4, 8'h70, 1);
		rd_chk(`REG_STR_DATA, 32'hff, 32'h0);
		str_fill(3'h5, 8'h70, 1);
		bus(`REG_CTRL, 1'b1, 32'h400);
		rd_chk(`REG_STATUS, 32'h30, 32'h10);
		bus(`REG_LOGOUT, 1'b1, 32'h1);
		esc_seq(1'b0);
		chk({session_active_o, session_modem_o}, 2'b11);
		local_pulse();
		chk({session_active_o, session_modem_o}, 2'b11);
		n = 0;
		while (session_active_o === 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		chk(n >= 95 && n <= 115, 1'b1);
		tick(1);
		chk(hang_cnt, 1);
		bus(`REG_LOGOUT, 1'b1, 32'h0);
		esc_seq(1'b0);
		tick(300);
		chk(session_active_o, 1'b1);
		bus(`REG_CTRL, 1'b1, 32'h100);
		tick(2);
		chk(session_active_o, 1'b0);
		bus(`REG_LOGOUT, 1'b1, 32'ha);
		rd_chk(`REG_LOGOUT, 32'hf, 32'h0);
		serial_flow_setting_i <= 1'b1;
		bus(`REG_CTRL, 1'b1, 32'h200);
		tick(2);
		chk({modem_flow_o, modem_cd_enable_o}, 2'b11);
		bus(`REG_CTRL, 1'b1, 32'h3);
		tick(2);
		chk({remote_enable_o, path_bypass_o}, 2'b01);
		i_far.send_host(8'h42);
		#1 chk(modem_valid_o, 1'b0);
		local_pulse();
		chk({session_active_o, session_modem_o}, 2'b10);
		local_pulse();
		chk({session_active_o, session_modem_o}, 2'b10);
		bus(`REG_CTRL, 1'b1, 32'h102);
		esc_seq(1'b1);
		chk(session_active_o, 1'b0);
		system_power_on_i <= 1'b0;
		tick(2);
		rd_chk(`REG_STATUS, 32'h3, 32'h1);
		esc_seq(1'b1);
		chk({session_active_o, session_modem_o}, 2'b11);
		i_far.set_carrier(1'b0);
		tick(3);
		chk({session_active_o, 28'(hang_cnt)}, 29'h3);
		system_power_on_i <= 1'b1;
		i_far.set_carrier(1'b1);
		bus(`REG_CTRL, 1'b1, 32'h2);
		alert_i <= 1'b1;
		tick(2);
		alert_i <= 1'b0;
		rd_chk(`REG_STATUS, 32'h3, 32'h1);
		bus(`REG_CTRL, 1'b1, 32'h2);
		i_far.set_carrier(1'b0);
		tick(2);
		rd_chk(`REG_STATUS, 32'h3, 32'h1);
		serial_flow_setting_i <= 1'b0;
		bus(`REG_CTRL, 1'b1, 32'h201);
		#1 chk({modem_init_o, modem_flow_o}, 2'b10);
		bus(`REG_BAUD, 1'b1, 32'h1c200);
		#1 chk(baud_rate_o, 18'h1c200);
		// second reset in mid-run: settings and password must return to defaults
		@(posedge sys_clk_i);
		resetn_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		rd_chk(`REG_STATUS, 32'hffffffff, 32'h0);
		chk({remote_enable_o, path_bypass_o, baud_rate_o}, 20'h82580);
		close_out();
	end
endmodule
